// ===== pps_cfg.svh
// constants for the periodic descriptor schedule register bank
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH
// command codes (read / write)
`define PPS_CMD_BLK_RD 8'h53
`define PPS_CMD_BLK_WR 8'hD3
`define PPS_CMD_DONE_RD 8'h17
`define PPS_CMD_SKIP_RD 8'h18
`define PPS_CMD_SKIP_WR 8'h98
`define PPS_CMD_LAST_RD 8'h19
`define PPS_CMD_LAST_WR 8'h99
`define PPS_CMD_ACT_RD 8'h1A
// field layout and reset values
`define PPS_BLK_MSB 9
`define PPS_IDX_MSB 4
`define PPS_BLK_RESET 10'h040
`define PPS_MAP_RESET 32'h0000_0000
// frame timing: 1 ms at 40 MHz
`define PPS_FRAME_US 1000
`define PPS_CLK_MHZ 40
`endif

// ===== pps_engine_model.sv
// transaction engine model answering issued descriptors
`timescale 1ns/10ps
// ====
module pps_engine_model (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // issue side and reply
  input wire logic issue_in,
  input wire logic [4:0] index_in,
  input wire logic [31:0] ack_mask_in,
  input wire logic slow_in,
  output logic retire_out,
  output logic acked_out
);
  logic [5:0] dly_r;
  logic ack_r;
  // one retire per issue, fast or slow so the bank waits either way
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dly_r <= '0;
      ack_r <= 1'b0;
    end else begin
      dly_r <= {dly_r[4:0], issue_in};
      if (issue_in) ack_r <= ack_mask_in[index_in];
    end
  end
  assign retire_out = slow_in ? dly_r[5] : dly_r[2];
  assign acked_out = retire_out & ack_r;
endmodule

// ===== pps_pkg.sv
// types for the periodic descriptor schedule register bank
package pps_pkg;
  typedef enum logic [1:0] {
    PPS_IDLE,
    PPS_SCAN,
    PPS_WAIT,
    PPS_APER
  } pps_state_t;
endpackage

// ===== pps_regs.sv
// periodic descriptor schedule register bank with command decode
//
// Summary of operation
// - ten-bit block size, upper 22 bits reserved
// - done map bit n tracks block n
// - done map published once per millisecond frame
// - reading done map clears it entirely
// - done bit set only on acknowledged completion
// - skip map read/write; set bits bypass descriptor
// - clearing skip bit resumes that descriptor
// - last map read/write marks final descriptor
// - after last descriptor, move to aperiodic list
// - read-only five-bit active index, reset zero
// - separate read/write command codes for block size, skip and last maps; read codes only for done map and active index
`timescale 1ns/10ps
`include "pps_cfg.svh"
module pps_regs
  import pps_pkg::*;
#(
  parameter int FRAME_CYCLES = `PPS_FRAME_US * `PPS_CLK_MHZ
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // command port from the host processor
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [31:0] cmd_wdata_in,
  // register read answer
  output logic [31:0] rdata_out,
  output logic rvalid_out,
  // transaction engine side
  input wire logic retire_in,
  input wire logic retire_acked_in,
  output logic issue_out,
  output logic [4:0] issue_index_out,
  output logic [15:0] issue_offset_out,
  output logic aper_start_out
);
  pps_sched_if sch ();

  // ============================================================
  // command decode
  wire blk_wr_w = cmd_valid_in && (cmd_code_in == `PPS_CMD_BLK_WR);
  wire skip_wr_w = cmd_valid_in && (cmd_code_in == `PPS_CMD_SKIP_WR);
  wire last_wr_w = cmd_valid_in && (cmd_code_in == `PPS_CMD_LAST_WR);
  wire done_rd_w = cmd_valid_in && (cmd_code_in == `PPS_CMD_DONE_RD);
  wire any_rd_w = cmd_valid_in && !cmd_code_in[7];

  // ============================================================
  // stored registers
  logic [9:0] blk_r;
  logic [31:0] skip_r;
  logic [31:0] last_r;
  logic [31:0] done_r;
  logic [31:0] pend_r;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) blk_r <= `PPS_BLK_RESET;
    else if (blk_wr_w) blk_r <= cmd_wdata_in[`PPS_BLK_MSB:0];
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) skip_r <= `PPS_MAP_RESET;
    else if (skip_wr_w) skip_r <= cmd_wdata_in;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) last_r <= `PPS_MAP_RESET;
    else if (last_wr_w) last_r <= cmd_wdata_in;
  end

  // ============================================================
  // done tracking: completions gather in pending, published each frame
  wire [31:0] ack_bit_w = (retire_in && retire_acked_in) ?
      (32'h0000_0001 << sch.current_entry_index) : 32'h0000_0000;
  wire [31:0] pend_nxt = sch.frame_done ? ack_bit_w : (pend_r | ack_bit_w);
  // a publish in the same cycle as a clearing read wins, so no frame is lost
  wire [31:0] done_nxt = sch.frame_done ? (done_rd_w ? pend_r : (done_r | pend_r)) :
      (done_rd_w ? 32'h0000_0000 : done_r);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pend_r <= `PPS_MAP_RESET;
      done_r <= `PPS_MAP_RESET;
    end else begin
      pend_r <= pend_nxt;
      done_r <= done_nxt;
    end
  end

  // ============================================================
  // read mux; reserved bits read zero, unmapped codes read zero
  logic [31:0] rmux_w;
  always_comb begin
    unique case (cmd_code_in)
      `PPS_CMD_BLK_RD: rmux_w = {22'h000000, blk_r};
      `PPS_CMD_DONE_RD: rmux_w = done_r;
      `PPS_CMD_SKIP_RD: rmux_w = skip_r;
      `PPS_CMD_LAST_RD: rmux_w = last_r;
      `PPS_CMD_ACT_RD: rmux_w = {27'h0000000, sch.current_entry_index};
      default: rmux_w = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 32'h0000_0000;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= any_rd_w;
      if (any_rd_w) rdata_out <= rmux_w;
    end
  end

  // ============================================================
  // schedule walker and registered engine outputs
  assign sch.bypass_flags = skip_r;
  assign sch.final_entry_flags = last_r;
  assign sch.partition_bytes = blk_r;
  assign sch.retire = retire_in;
  assign sch.retire_acked = retire_acked_in;

  pps_walker #(.FRAME_CYCLES(FRAME_CYCLES)) u_walk (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .sch(sch)
  );

  // outputs registered, so the engine sees them one cycle late
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      issue_out <= 1'b0;
      issue_index_out <= 5'h00;
      issue_offset_out <= 16'h0000;
      aper_start_out <= 1'b0;
    end else begin
      issue_out <= sch.issue && !issue_out;
      issue_index_out <= sch.current_entry_index;
      issue_offset_out <= sch.entry_offset;
      aper_start_out <= sch.aper_start;
    end
  end
endmodule

// ===== pps_regs_props.sv
// assertion checker for the periodic schedule register bank
`timescale 1ns/10ps
`include "pps_cfg.svh"
// ====
module pps_regs_props #(parameter int FRAME_CYCLES = 64) (
  // clock, reset, command port
  input wire logic core_clk_in, resetn_in, cmd_valid_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [31:0] cmd_wdata_in, rdata_out,
  // answers and engine side
  input wire logic rvalid_out, retire_in, retire_acked_in, issue_out, aper_start_out,
  input wire logic [4:0] issue_index_out,
  input wire logic [15:0] issue_offset_out
);
  logic [31:0] skip_r, last_r;
  // decode kept as wires so shadows stay short
  wire rd = cmd_valid_in & ~cmd_code_in[7];
  wire wr_skip = cmd_valid_in && cmd_code_in == `PPS_CMD_SKIP_WR;
  wire wr_last = cmd_valid_in && cmd_code_in == `PPS_CMD_LAST_WR;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // shadow maps, to judge read-back without peeking inside
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      skip_r <= '0;
      last_r <= '0;
    end else begin
      if (wr_skip) skip_r <= cmd_wdata_in;
      if (wr_last) last_r <= cmd_wdata_in;
    end
  end
  sequence read_of(c);
    cmd_valid_in && cmd_code_in == c;
  endsequence
  chk_read_answer: assert property (rd |=> rvalid_out) else $error("read not answered");
  chk_no_stray: assert property (!rd |=> !rvalid_out) else $error("stray read answer");
  chk_skip_back: assert property (read_of(`PPS_CMD_SKIP_RD) |=> rdata_out == $past(skip_r))
    else $error("skip map readback wrong");
  chk_last_back: assert property (read_of(`PPS_CMD_LAST_RD) |=> rdata_out == $past(last_r))
    else $error("last map readback wrong");
  chk_index_rsvd: assert property (read_of(`PPS_CMD_ACT_RD) |=> rdata_out[31:5] == '0)
    else $error("index reserved bits set");
  chk_not_skipped: assert property (issue_out |-> !skip_r[issue_index_out])
    else $error("skipped entry issued");
  chk_retire_next: assert property (retire_in |-> ##[1:40] (issue_out || aper_start_out))
    else $error("no progress after retire");
  chk_aper_pulse: assert property (aper_start_out |=> !aper_start_out[*8])
    else $error("aperiodic start repeated");
endmodule
bind pps_regs pps_regs_props #(.FRAME_CYCLES(FRAME_CYCLES)) u_props (.*);

// ===== pps_sched_if.sv
// signals passed between the register bank and the schedule walker
`timescale 1ns/10ps
interface pps_sched_if;
  logic [31:0] bypass_flags;
  logic [31:0] final_entry_flags;
  logic [9:0] partition_bytes;
  logic [4:0] current_entry_index;
  logic [15:0] entry_offset;
  logic issue;
  logic retire;
  logic retire_acked;
  logic frame_done;
  logic aper_start;
  modport walker (
    input bypass_flags, final_entry_flags, partition_bytes,
    output current_entry_index, entry_offset, issue, frame_done, aper_start,
    input retire, retire_acked
  );
  modport bank (
    output bypass_flags, final_entry_flags, partition_bytes,
    input current_entry_index, entry_offset, issue, frame_done, aper_start,
    output retire, retire_acked
  );
endinterface

// ===== pps_walker.sv
// per-frame walker over the interrupt-list descriptors
`timescale 1ns/10ps
`include "pps_cfg.svh"
module pps_walker
  import pps_pkg::*;
#(
  parameter int FRAME_CYCLES = `PPS_FRAME_US * `PPS_CLK_MHZ
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // schedule side
  pps_sched_if.walker sch
);
  // ============================================================
  // frame tick
  logic [31:0] tick_cnt_r;
  wire tick_w = (tick_cnt_r == 32'(FRAME_CYCLES - 1));
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) tick_cnt_r <= 32'h0000_0000;
    else tick_cnt_r <= tick_w ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
  end

  // ============================================================
  // walk state
  pps_state_t state_r;
  pps_state_t state_nxt;
  logic [4:0] idx_r;
  logic [4:0] idx_nxt;
  wire skip_w = sch.bypass_flags[idx_r];
  wire last_w = sch.final_entry_flags[idx_r];
  wire wrap_w = (idx_r == 5'h1F);

  // next-state decode; skipped entries advance without issue
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    unique case (state_r)
      PPS_IDLE: begin
        if (tick_w) begin
          state_nxt = PPS_SCAN;
          idx_nxt = 5'h00;
        end
      end
      PPS_SCAN: begin
        if (skip_w) begin
          if (last_w || wrap_w) state_nxt = PPS_APER;
          else idx_nxt = idx_r + 5'h01;
        end else state_nxt = PPS_WAIT;
      end
      PPS_WAIT: begin
        if (sch.retire) begin
          if (last_w || wrap_w) state_nxt = PPS_APER;
          else begin
            state_nxt = PPS_SCAN;
            idx_nxt = idx_r + 5'h01;
          end
        end
      end
      PPS_APER: state_nxt = PPS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= PPS_IDLE;
      idx_r <= 5'h00;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
    end
  end

  assign sch.current_entry_index = idx_r;
  // descriptor n starts n blocks into the buffer
  assign sch.entry_offset = 16'(idx_r) * 16'(sch.partition_bytes);
  assign sch.issue = (state_r == PPS_SCAN) && !skip_w;
  assign sch.frame_done = (state_r == PPS_APER);
  assign sch.aper_start = (state_r == PPS_APER);
endmodule

// ===== tb_top.sv
// self-checking bench for the periodic schedule register bank
`timescale 1ns/10ps
`include "pps_cfg.svh"
// ====
module tb_top;
  logic core_clk_in, resetn_in, cmd_valid_in, rvalid_out, retire_in, retire_acked_in;
  logic issue_out, aper_start_out, slow;
  logic [7:0] cmd_code_in;
  logic [31:0] cmd_wdata_in, rdata_out, ack_mask, seen;
  logic [4:0] issue_index_out;
  logic [15:0] issue_offset_out, blk;
  int err_count = 0, checks = 0, cyc = 0;
  pps_regs #(.FRAME_CYCLES(64)) uut (.*);
  pps_engine_model eng (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .issue_in(issue_out),
    .index_in(issue_index_out), .ack_mask_in(ack_mask), .slow_in(slow), .retire_out(retire_in),
    .acked_out(retire_acked_in));
  initial begin
    core_clk_in = 0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  // automatic, since the issue monitor and a scenario may compare in the same time step
  task automatic check(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wr(logic [7:0] c, logic [31:0] d);
    @(posedge core_clk_in);
    cmd_valid_in <= 1;
    cmd_code_in <= c;
    cmd_wdata_in <= d;
    @(posedge core_clk_in);
    cmd_valid_in <= 0;
  endtask
  // the answer pulse stands only in the cycle after the command edge, so judge it there
  task rd(logic [7:0] c, logic [31:0] exp);
    wr(c, 32'h0);
    #1;
    check(rvalid_out, 32'h1);
    check(rdata_out, exp);
  endtask
  // offsets judged at every issue; a hang here is caught by the cycle ceiling
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      finish_test;
    end
    if (issue_out) begin
      check(issue_offset_out, 16'(issue_index_out) * blk);
    end
  end
  // collects issued indices until the aperiodic start pulse; a missing pulse is a mismatch
  task wait_aper;
    seen = '0;
    for (int i = 0; i < 200 && !aper_start_out; i++) begin
      @(posedge core_clk_in);
      if (issue_out) seen[issue_index_out] = 1'b1;
    end
    check(aper_start_out, 32'h1);
  endtask
  task t_reset;
    rd(`PPS_CMD_BLK_RD, 32'h40);
    rd(`PPS_CMD_DONE_RD, 32'h0);
    rd(`PPS_CMD_SKIP_RD, 32'h0);
    rd(`PPS_CMD_LAST_RD, 32'h0);
    rd(`PPS_CMD_ACT_RD, 32'h0);
    rd(8'h20, 32'h0);
    wr(`PPS_CMD_BLK_WR, 32'hFFFF_FE00);
    rd(`PPS_CMD_BLK_RD, 32'h200);
    wr(`PPS_CMD_BLK_WR, 32'h20);
    blk = 16'h20;
    $display("reset and block size done");
  endtask
  task t_frame;
    wr(`PPS_CMD_SKIP_WR, 32'h2);
    wr(`PPS_CMD_LAST_WR, 32'h8);
    rd(`PPS_CMD_LAST_RD, 32'h8);
    wait_aper;
    check(seen, 32'hD);
    rd(`PPS_CMD_DONE_RD, 32'h9);
    rd(`PPS_CMD_DONE_RD, 32'h0);
    $display("skipped frame done");
  endtask
  task t_resume;
    slow = 1;
    rd(`PPS_CMD_ACT_RD, 32'h3);
    wr(`PPS_CMD_SKIP_WR, 32'h0);
    wait_aper;
    check(seen, 32'hF);
    rd(`PPS_CMD_DONE_RD, 32'h9);
    $display("resume frame done");
  endtask
  initial begin
    resetn_in = 0;
    cmd_valid_in = 0;
    cmd_code_in = 0;
    cmd_wdata_in = 0;
    ack_mask = 32'h9;
    slow = 0;
    blk = 16'h40;
    repeat (2) @(posedge core_clk_in);
    resetn_in <= 1;
    t_reset;
    t_frame;
    t_resume;
    finish_test;
  end
endmodule
